// ==== prw_pkg.sv ====
/*
  Constants for the remote window mapper: configuration slots, window sizes,
  control block layout, entry fields and timing.
  Assumes a single 25 MHz clock and synchronous inputs.
*/
package prw_pkg;
  // Clock and timing
  localparam int CLK_MHZ = 25;
  localparam int TMO_US = 20;
  localparam int TMO_CYC = TMO_US * CLK_MHZ;
  localparam logic [9:0] TMO_LAST = 10'(TMO_CYC - 1);
  // Configuration longword offsets
  localparam logic [7:0] CFG_IO_BASE = 8'h10;
  localparam logic [7:0] CFG_MEM_BASE = 8'h14;
  localparam logic [7:0] CFG_TBL_BASE = 8'h18;
  localparam logic [7:0] CFG_WIN_BASE = 8'h1C;
  // Address bits decoded by each base (window size masks)
  localparam logic [31:0] CSR_MASK = 32'hFFFF_FFE0;
  localparam logic [31:0] TBL_MASK = 32'hFFFC_0000;
  localparam logic [31:0] WIN_MASK = 32'hFE00_0000;
  localparam logic [31:0] IO_SPACE = 32'h0000_0001;
  localparam logic [31:0] BASE_RST = 32'h0000_0000;
  // Translation table regions (word index bits 15:12)
  localparam logic [17:0] TBL_FWD_LO = 18'h0_0000;
  localparam logic [17:0] TBL_FWD_HI = 18'h0_3FFF;
  localparam logic [17:0] TBL_RSV_LO = 18'h0_4000;
  localparam logic [17:0] TBL_RSV_HI = 18'h0_7FFF;
  localparam logic [17:0] TBL_INB_LO = 18'h0_8000;
  localparam logic [17:0] TBL_INB_HI = 18'h0_BFFF;
  localparam logic [17:0] TBL_DMA_LO = 18'h0_C000;
  localparam logic [17:0] TBL_DMA_HI = 18'h0_FFFF;
  localparam logic [17:0] TBL_SHM_LO = 18'h1_0000;
  localparam int TBL_WORDS = 65536;
  // Control block offsets and bits
  localparam logic [4:0] CSR_LSTAT = 5'h00;
  localparam logic [4:0] CSR_LCMD = 5'h04;
  localparam logic [4:0] CSR_RSTAT = 5'h08;
  localparam int LSTAT_NOLINK = 0;
  localparam int LSTAT_IFERR = 1;
  localparam int LSTAT_CBLERR = 2;
  localparam int LSTAT_TMOERR = 3;
  localparam int LCMD_CLR = 7;
  localparam logic [7:0] LCMD_RST = 8'h00;
  // Entry fields
  localparam int ENT_INVALID = 0;
  localparam int ENT_SWAP_LO = 1;
  localparam int ENT_DEST_LO = 4;
  localparam int ENT_AM_LO = 6;
  localparam int ENT_ADDR_LO = 12;
  localparam logic [1:0] DEST_RSV = 2'h0;
  // Access engine states
  typedef enum logic [1:0] {
    PRW_IDLE = 2'h0,
    PRW_REMOTE = 2'h1,
    PRW_TMO = 2'h3
  } prw_state_e;
endpackage : prw_pkg

// ==== prw_mapper.sv ====
/*
  Remote window mapper: configuration bases, control block, translation table
  with shared memory, remote window translation and indicators.
  Assumes one host access at a time, with its request high for one cycle only.
*/
`timescale 1ns/100ps
module prw_mapper (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_in,
  // Configuration access
  input wire logic cfg_we_in,
  input wire logic cfg_re_in,
  input wire logic [7:0] cfg_off_in,
  input wire logic [31:0] cfg_wdata_in,
  output logic [31:0] cfg_rdata_out,
  // Host target access
  input wire logic tgt_req_in,
  input wire logic tgt_write_in,
  input wire logic tgt_io_in,
  input wire logic [31:0] tgt_addr_in,
  input wire logic [3:0] tgt_be_in,
  input wire logic [31:0] tgt_wdata_in,
  output logic tgt_busy_out,
  output logic tgt_ack_out,
  output logic tgt_err_out,
  output logic [31:0] tgt_rdata_out,
  // Remote cycle
  output logic rmt_req_out,
  output logic rmt_write_out,
  output logic [31:0] rmt_addr_out,
  output logic [3:0] rmt_be_out,
  output logic [31:0] rmt_wdata_out,
  output logic [5:0] rmt_am_out,
  output logic destination_select_high_out,
  output logic destination_select_low_out,
  output logic [2:0] rmt_swap_out,
  input wire logic rmt_ack_in,
  input wire logic [31:0] rmt_rdata_in,
  // Link and card status
  input wire logic remote_power_in,
  input wire logic cable_present_in,
  input wire logic cable_err_in,
  input wire logic [31:0] remote_status_in,
  input wire logic logic_loaded_in,
  input wire logic dma_active_in,
  input wire logic remote_master_in,
  // Indicators
  output logic loaded_indicator_out,
  output logic local_activity_indicator_out,
  output logic remote_activity_indicator_out
);

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lane_merge(input logic [31:0] old_w,
      input logic [31:0] new_w, input logic [3:0] be);
    logic [31:0] r;
    r = old_w;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = new_w[8*i +: 8];
      end
    end
    return r;
  endfunction : lane_merge

  function automatic logic base_hit(input logic [31:0] a, input logic [31:0] b,
      input logic [31:0] m);
    return (a & m) == (b & m);
  endfunction : base_hit

  ////////////////////////////////////////////////////////////////////////////
  logic [31:0] csr_io_base;
  logic [31:0] csr_memory_base;
  logic [31:0] translation_table_base;
  logic [31:0] remote_window_base;
  logic [31:0] table_mem [0:prw_pkg::TBL_WORDS-1];
  logic [7:0] lcmd;
  logic iferr;
  logic cblerr;
  logic tmoerr;
  logic [9:0] tmo_cnt;
  prw_pkg::prw_state_e state;

  // Base registers: bits below the window size read zero, except bit 0 of the I/O base, which reads one
  wire logic [31:0] io_bar_rd = (csr_io_base & prw_pkg::CSR_MASK) | prw_pkg::IO_SPACE;
  wire logic [31:0] mem_bar_rd = csr_memory_base & prw_pkg::CSR_MASK;
  wire logic [31:0] tbl_bar_rd = translation_table_base & prw_pkg::TBL_MASK;
  wire logic [31:0] win_bar_rd = remote_window_base & prw_pkg::WIN_MASK;

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      csr_io_base <= prw_pkg::BASE_RST;
      csr_memory_base <= prw_pkg::BASE_RST;
      translation_table_base <= prw_pkg::BASE_RST;
      remote_window_base <= prw_pkg::BASE_RST;
    end else if (cfg_we_in) begin
      if (cfg_off_in == prw_pkg::CFG_IO_BASE) csr_io_base <= cfg_wdata_in;
      if (cfg_off_in == prw_pkg::CFG_MEM_BASE) csr_memory_base <= cfg_wdata_in;
      if (cfg_off_in == prw_pkg::CFG_TBL_BASE) translation_table_base <= cfg_wdata_in;
      if (cfg_off_in == prw_pkg::CFG_WIN_BASE) remote_window_base <= cfg_wdata_in;
    end
  end

  wire logic [31:0] next_cfg_rdata =
      (cfg_off_in == prw_pkg::CFG_IO_BASE) ? io_bar_rd :
      (cfg_off_in == prw_pkg::CFG_MEM_BASE) ? mem_bar_rd :
      (cfg_off_in == prw_pkg::CFG_TBL_BASE) ? tbl_bar_rd :
      (cfg_off_in == prw_pkg::CFG_WIN_BASE) ? win_bar_rd : 32'h0000_0000;

  always_ff @(posedge mclk_in) begin
    if (rst_in) cfg_rdata_out <= 32'h0000_0000;
    else if (cfg_re_in) cfg_rdata_out <= next_cfg_rdata;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Target decode
  wire logic take = tgt_req_in && (state == prw_pkg::PRW_IDLE);
  wire logic hit_csr = tgt_io_in ? base_hit(tgt_addr_in, csr_io_base, prw_pkg::CSR_MASK)
                                 : base_hit(tgt_addr_in, csr_memory_base, prw_pkg::CSR_MASK);
  wire logic hit_tbl = !tgt_io_in &&
      base_hit(tgt_addr_in, translation_table_base, prw_pkg::TBL_MASK);
  wire logic hit_win = !tgt_io_in &&
      base_hit(tgt_addr_in, remote_window_base, prw_pkg::WIN_MASK);
  wire logic [4:0] csr_off = {tgt_addr_in[4:2], 2'b00};
  wire logic [15:0] tbl_idx = tgt_addr_in[17:2];
  wire logic [12:0] win_idx = tgt_addr_in[24:12];
  wire logic [31:0] entry = table_mem[{3'b000, win_idx}];
  wire logic linked = remote_power_in && cable_present_in;
  wire logic tbl_width_ok = (tgt_be_in == 4'hF) || (tgt_be_in == 4'h3) ||
                            (tgt_be_in == 4'hC);
  wire logic tbl_bad = hit_tbl && !tbl_width_ok;
  wire logic win_unlinked = hit_win && !linked;
  // With the link up, an invalid entry times out whatever its destination code says
  wire logic win_rsv = hit_win && !entry[prw_pkg::ENT_INVALID] &&
                       (entry[prw_pkg::ENT_DEST_LO +: 2] == prw_pkg::DEST_RSV);
  wire logic win_invalid = hit_win && entry[prw_pkg::ENT_INVALID];
  wire logic win_go = hit_win && linked && !win_rsv && !win_invalid;
  wire logic local_ok = (hit_csr || hit_tbl) && !tbl_bad;
  wire logic bad_now = tbl_bad || win_unlinked || win_rsv ||
                       !(hit_csr || hit_tbl || hit_win);
  wire logic [31:0] remote_addr = {entry[31:prw_pkg::ENT_ADDR_LO],
                                   tgt_addr_in[prw_pkg::ENT_ADDR_LO-1:0]};

  wire logic [7:0] lstat = {4'h0, tmoerr, cblerr, iferr, !linked};
  wire logic [31:0] csr_rd =
      (csr_off == prw_pkg::CSR_LSTAT) ? {24'h00_0000, lstat} :
      (csr_off == prw_pkg::CSR_LCMD) ? {24'h00_0000, lcmd} :
      (csr_off == prw_pkg::CSR_RSTAT) ? remote_status_in : 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////
  // Table and shared memory; byte-wide writes are refused
  always_ff @(posedge mclk_in) begin
    if (take && hit_tbl && tgt_write_in && tbl_width_ok) begin
      table_mem[tbl_idx] <= lane_merge(table_mem[tbl_idx], tgt_wdata_in, tgt_be_in);
    end
  end

  // Control block and sticky errors; a new event wins over a clear
  wire logic csr_wr = take && hit_csr && tgt_write_in;
  wire logic clr_all = csr_wr && (csr_off == prw_pkg::CSR_LCMD) &&
                       tgt_be_in[0] && tgt_wdata_in[prw_pkg::LCMD_CLR];
  wire logic rstat_rd = take && hit_csr && !tgt_write_in &&
                        (csr_off == prw_pkg::CSR_RSTAT);
  wire logic tmo_done = (state == prw_pkg::PRW_TMO) && (tmo_cnt == prw_pkg::TMO_LAST);

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      lcmd <= prw_pkg::LCMD_RST;
      iferr <= 1'b0;
      cblerr <= 1'b0;
      tmoerr <= 1'b0;
    end else begin
      if (csr_wr && (csr_off == prw_pkg::CSR_LCMD) && tgt_be_in[0]) begin
        lcmd <= {1'b0, tgt_wdata_in[6:0]};
      end
      iferr <= win_unlinked && take ? 1'b1 : (clr_all ? 1'b0 : iferr);
      cblerr <= cable_err_in ? 1'b1 : ((clr_all || rstat_rd) ? 1'b0 : cblerr);
      tmoerr <= tmo_done ? 1'b1 : (clr_all ? 1'b0 : tmoerr);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Access engine
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      state <= prw_pkg::PRW_IDLE;
      tmo_cnt <= 10'h000;
    end else begin
      unique case (state)
        prw_pkg::PRW_IDLE: begin
          tmo_cnt <= 10'h000;
          if (take && win_go) state <= prw_pkg::PRW_REMOTE;
          else if (take && win_invalid && linked) state <= prw_pkg::PRW_TMO;
        end
        prw_pkg::PRW_REMOTE: begin
          if (rmt_ack_in) state <= prw_pkg::PRW_IDLE;
        end
        prw_pkg::PRW_TMO: begin
          tmo_cnt <= tmo_cnt + 10'h001;
          if (tmo_done) state <= prw_pkg::PRW_IDLE;
        end
        default: state <= prw_pkg::PRW_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      rmt_req_out <= 1'b0;
      rmt_write_out <= 1'b0;
      rmt_addr_out <= 32'h0000_0000;
      rmt_be_out <= 4'h0;
      rmt_wdata_out <= 32'h0000_0000;
      rmt_am_out <= 6'h00;
      destination_select_high_out <= 1'b0;
      destination_select_low_out <= 1'b0;
      rmt_swap_out <= 3'h0;
    end else if (take && win_go) begin
      rmt_req_out <= 1'b1;
      rmt_write_out <= tgt_write_in;
      rmt_be_out <= tgt_be_in;
      rmt_wdata_out <= tgt_wdata_in;
      rmt_addr_out <= remote_addr;
      rmt_am_out <= entry[prw_pkg::ENT_AM_LO +: 6];
      destination_select_high_out <= entry[prw_pkg::ENT_DEST_LO + 1];
      destination_select_low_out <= entry[prw_pkg::ENT_DEST_LO];
      rmt_swap_out <= entry[prw_pkg::ENT_SWAP_LO +: 3];
    end else if (rmt_ack_in) begin
      rmt_req_out <= 1'b0;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      tgt_ack_out <= 1'b0;
      tgt_err_out <= 1'b0;
      tgt_rdata_out <= 32'h0000_0000;
    end else begin
      tgt_ack_out <= (take && (local_ok || bad_now)) ||
                     (state == prw_pkg::PRW_REMOTE && rmt_ack_in) || tmo_done;
      tgt_err_out <= (take && bad_now) || tmo_done;
      if (take && hit_csr && !tgt_write_in) tgt_rdata_out <= csr_rd;
      else if (take && hit_tbl && !tgt_write_in) tgt_rdata_out <= table_mem[tbl_idx];
      else if (state == prw_pkg::PRW_REMOTE && rmt_ack_in) tgt_rdata_out <= rmt_rdata_in;
    end
  end

  assign tgt_busy_out = (state != prw_pkg::PRW_IDLE);
  assign loaded_indicator_out = logic_loaded_in;
  assign local_activity_indicator_out = tgt_busy_out || tgt_ack_out || dma_active_in;
  assign remote_activity_indicator_out = remote_master_in;

  ////////////////////////////////////////////////////////////////////////////
  a_local_answer: assert property (@(posedge mclk_in) disable iff (rst_in)
    take && local_ok |=> tgt_ack_out && !tgt_err_out)
    else $error("local access not answered next cycle");

  a_byte_refused: assert property (@(posedge mclk_in) disable iff (rst_in)
    take && tbl_bad && tgt_write_in |=> tgt_err_out &&
      table_mem[$past(tbl_idx)] == $past(table_mem[tbl_idx]))
    else $error("byte write to table not refused");

  a_remote_addr_form: assert property (@(posedge mclk_in) disable iff (rst_in)
    take && win_go |=> rmt_req_out && rmt_addr_out[11:0] == $past(tgt_addr_in[11:0])
      && rmt_addr_out[31:12] == $past(entry[31:12]))
    else $error("remote address formed wrongly");

  a_unlinked_error: assert property (@(posedge mclk_in) disable iff (rst_in)
    take && win_unlinked |=> tgt_err_out && !rmt_req_out ##1 lstat[prw_pkg::LSTAT_IFERR])
    else $error("unlinked remote access not flagged");

  a_invalid_timeout: assert property (@(posedge mclk_in) disable iff (rst_in)
    take && win_invalid && linked |=> !rmt_req_out ##[490:510] tgt_err_out)
    else $error("invalid entry did not time out");

  a_clear_errors: assert property (@(posedge mclk_in) disable iff (rst_in)
    clr_all && !cable_err_in && !tmo_done |=> lstat[3:1] == 3'h0)
    else $error("error clear command ignored");

  a_rstat_clear: assert property (@(posedge mclk_in) disable iff (rst_in)
    rstat_rd && !cable_err_in |=> !cblerr)
    else $error("remote status read left cable error");

  a_set_wins: assert property (@(posedge mclk_in) disable iff (rst_in)
    cable_err_in |=> cblerr)
    else $error("cable error event lost");

  a_local_led: assert property (@(posedge mclk_in) disable iff (rst_in)
    tgt_busy_out || dma_active_in |-> local_activity_indicator_out)
    else $error("local activity indicator dark while busy");

  a_link_status: assert property (@(posedge mclk_in) disable iff (rst_in)
    (remote_power_in && cable_present_in) == !lstat[prw_pkg::LSTAT_NOLINK])
    else $error("link status bit wrong");

  a_remote_hold: assert property (@(posedge mclk_in) disable iff (rst_in)
    rmt_req_out && !rmt_ack_in |=> rmt_req_out && $stable(rmt_addr_out) &&
      $stable(rmt_wdata_out) && $stable(rmt_be_out) && $stable(rmt_write_out))
    else $error("remote cycle changed before acknowledge");

  a_remote_release: assert property (@(posedge mclk_in) disable iff (rst_in)
    state == prw_pkg::PRW_REMOTE && rmt_ack_in |=> !rmt_req_out && tgt_ack_out &&
      !tgt_busy_out)
    else $error("remote completion not passed to host");

  a_dest_select: assert property (@(posedge mclk_in) disable iff (rst_in)
    take && win_go |=> {destination_select_high_out, destination_select_low_out} != 2'b00 &&
      rmt_am_out == $past(entry[11:6]))
    else $error("destination or modifier wrong");

  a_table_readback: assert property (@(posedge mclk_in) disable iff (rst_in)
    cfg_re_in && cfg_off_in == prw_pkg::CFG_TBL_BASE |=> cfg_rdata_out[17:0] == 18'h0_0000)
    else $error("table base low bits not zero");

  a_window_readback: assert property (@(posedge mclk_in) disable iff (rst_in)
    cfg_re_in && cfg_off_in == prw_pkg::CFG_WIN_BASE |=> cfg_rdata_out[24:0] == 25'h000_0000)
    else $error("window base low bits not zero");

  a_table_write: assert property (@(posedge mclk_in) disable iff (rst_in)
    take && hit_tbl && tgt_write_in && tgt_be_in == 4'hF |=>
      table_mem[$past(tbl_idx)] == $past(tgt_wdata_in))
    else $error("table longword write lost");

  a_timeout_flag: assert property (@(posedge mclk_in) disable iff (rst_in)
    tmo_done |=> lstat[prw_pkg::LSTAT_TMOERR] && tgt_err_out)
    else $error("timeout not recorded");

endmodule : prw_mapper

// ==== prw_remote_responder.sv ====
/*
  Remote side model: answers each remote cycle of the mapper after a chosen
  number of cycles. Assumes the mapper holds its remote request until acknowledged.
*/
`timescale 1ns/100ps
module prw_remote_responder (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_in,
  // Remote cycle from the mapper
  input wire logic rmt_req_in,
  input wire logic [31:0] rmt_addr_in,
  input wire logic [7:0] delay_in,
  output logic rmt_ack_out,
  output logic [31:0] rmt_rdata_out
);
  logic [7:0] wait_cnt;
  logic done;
  always @(posedge mclk_in) begin
    rmt_ack_out <= 1'b0;
    if (rst_in) begin
      wait_cnt <= 8'h00;
      done <= 1'b0;
      rmt_rdata_out <= 32'hC3C3_3C3C;
    end else if (rmt_req_in && !done) begin
      if (wait_cnt == delay_in) begin
        rmt_ack_out <= 1'b1;
        done <= 1'b1;
        rmt_rdata_out <= rmt_addr_in ^ 32'h5A5A_0000;
      end else begin
        wait_cnt <= wait_cnt + 8'h01;
      end
    end else if (!rmt_req_in) begin
      // Data lines are not held once the cycle is over
      wait_cnt <= 8'h00;
      done <= 1'b0;
      rmt_rdata_out <= ~rmt_rdata_out;
    end
  end
endmodule : prw_remote_responder

// ==== pci_remote_window_mapper_tb.sv ====
/*
  Self-checking bench for the remote window mapper.
  Assumes the remote responder model answers remote cycles.
*/
`timescale 1ns/100ps
module pci_remote_window_mapper_tb;
  logic mclk_in = 1'b0, rst_in = 1'b1, cfg_we_in = 1'b0, cfg_re_in = 1'b0;
  logic [7:0] cfg_off_in = 8'h00, delay = 8'h00;
  logic [31:0] cfg_wdata_in = 32'h0, tgt_addr_in = 32'h0, tgt_wdata_in = 32'h0;
  logic tgt_req_in = 1'b0, tgt_write_in = 1'b0, tgt_io_in = 1'b0, remote_power_in = 1'b1;
  logic [3:0] tgt_be_in = 4'hF;
  logic cable_present_in = 1'b1, cable_err_in = 1'b0, logic_loaded_in = 1'b0;
  logic dma_active_in = 1'b0, remote_master_in = 1'b0, rmt_ack_in;
  logic [31:0] remote_status_in = 32'h0000_00C5, rmt_rdata_in, cfg_rdata_out, tgt_rdata_out;
  logic [31:0] rmt_addr_out, rmt_wdata_out, rd, cap_addr, cap_wd;
  logic tgt_busy_out, tgt_ack_out, tgt_err_out, rmt_req_out, rmt_write_out, err;
  logic [3:0] rmt_be_out;
  logic [5:0] rmt_am_out;
  logic [2:0] rmt_swap_out;
  logic dsh, dsl, loaded_ind, local_ind, remote_ind, act;
  logic [15:0] cap;
  int miscompares = 0;
  int n_compared = 0;

  prw_mapper i_prw_mapper (.mclk_in(mclk_in), .rst_in(rst_in), .cfg_we_in(cfg_we_in),
    .cfg_re_in(cfg_re_in), .cfg_off_in(cfg_off_in), .cfg_wdata_in(cfg_wdata_in),
    .cfg_rdata_out(cfg_rdata_out), .tgt_req_in(tgt_req_in), .tgt_write_in(tgt_write_in),
    .tgt_io_in(tgt_io_in), .tgt_addr_in(tgt_addr_in), .tgt_be_in(tgt_be_in),
    .tgt_wdata_in(tgt_wdata_in), .tgt_busy_out(tgt_busy_out), .tgt_ack_out(tgt_ack_out),
    .tgt_err_out(tgt_err_out), .tgt_rdata_out(tgt_rdata_out), .rmt_req_out(rmt_req_out),
    .rmt_write_out(rmt_write_out), .rmt_addr_out(rmt_addr_out), .rmt_be_out(rmt_be_out),
    .rmt_wdata_out(rmt_wdata_out), .rmt_am_out(rmt_am_out),
    .destination_select_high_out(dsh), .destination_select_low_out(dsl),
    .rmt_swap_out(rmt_swap_out), .rmt_ack_in(rmt_ack_in), .rmt_rdata_in(rmt_rdata_in),
    .remote_power_in(remote_power_in), .cable_present_in(cable_present_in),
    .cable_err_in(cable_err_in), .remote_status_in(remote_status_in),
    .logic_loaded_in(logic_loaded_in), .dma_active_in(dma_active_in),
    .remote_master_in(remote_master_in), .loaded_indicator_out(loaded_ind),
    .local_activity_indicator_out(local_ind), .remote_activity_indicator_out(remote_ind));
  prw_remote_responder i_prw_remote_responder (.mclk_in(mclk_in), .rst_in(rst_in),
    .rmt_req_in(rmt_req_out), .rmt_addr_in(rmt_addr_out), .delay_in(delay),
    .rmt_ack_out(rmt_ack_in), .rmt_rdata_out(rmt_rdata_in));

  initial begin
    forever #20 mclk_in = ~mclk_in;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up;
    $display("Compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : wrap_up
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic cfg(input logic [7:0] off, input logic [31:0] wd, input logic [31:0] exp);
    @(posedge mclk_in);
    cfg_we_in <= 1'b1;
    cfg_off_in <= off;
    cfg_wdata_in <= wd;
    @(posedge mclk_in);
    cfg_we_in <= 1'b0;
    cfg_re_in <= 1'b1;
    @(posedge mclk_in);
    cfg_re_in <= 1'b0;
    #1 check("config base", cfg_rdata_out, exp);
  endtask : cfg
  task automatic host(input logic wr, input logic io, input logic [31:0] a, input logic [3:0] be,
                      input logic [31:0] wd);
    int i;
    @(posedge mclk_in);
    tgt_req_in <= 1'b1;
    tgt_write_in <= wr;
    tgt_io_in <= io;
    tgt_addr_in <= a;
    tgt_be_in <= be;
    tgt_wdata_in <= wd;
    @(posedge mclk_in);
    tgt_req_in <= 1'b0;
    for (i = 0; i < 700; i++) begin
      #1;
      if (rmt_req_out === 1'b1) begin
        cap = {rmt_write_out, rmt_be_out, rmt_am_out, dsh, dsl, rmt_swap_out};
        cap_addr = rmt_addr_out;
        cap_wd = rmt_wdata_out;
        act = local_ind && tgt_busy_out;
      end
      if (tgt_ack_out === 1'b1) break;
      @(posedge mclk_in);
    end
    if (i == 700) begin
      check("host ack", 32'h0, 32'h1);
      wrap_up();
    end
    err = tgt_err_out;
    rd = tgt_rdata_out;
  endtask : host
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_bases;
    cfg(8'h10, 32'h0000_1003, 32'h0000_1001);
    cfg(8'h14, 32'h2000_001F, 32'h2000_0000);
    cfg(8'h18, 32'h4000_000F, 32'h4000_0000);
    cfg(8'h1C, 32'h8123_4567, 32'h8000_0000);
  endtask : t_bases
  task automatic t_table;
    host(1'b1, 1'b0, 32'h4000_0010, 4'hF, 32'h1234_5F6A);
    host(1'b1, 1'b0, 32'h4000_0018, 4'hF, 32'h0000_0000);
    host(1'b1, 1'b0, 32'h4000_001C, 4'hF, 32'h0000_0021);
    host(1'b1, 1'b0, 32'h4000_8004, 4'hF, 32'h0BAD_F00D);
    host(1'b0, 1'b0, 32'h4000_8004, 4'hF, 32'h0);
    check("inbound entry", rd, 32'h0BAD_F00D);
    host(1'b1, 1'b0, 32'h4000_FFFC, 4'h3, 32'h0000_7777);
    host(1'b0, 1'b0, 32'h4000_FFFC, 4'hF, 32'h0);
    check("block entry low word", {16'h0, rd[15:0]}, 32'h0000_7777);
    host(1'b1, 1'b0, 32'h4001_0000, 4'hF, 32'hA5A5_5A5A);
    host(1'b1, 1'b0, 32'h4003_FFFC, 4'hF, 32'h3C3C_C3C3);
    host(1'b0, 1'b0, 32'h4001_0000, 4'hF, 32'h0);
    check("shared first", rd, 32'hA5A5_5A5A);
    host(1'b0, 1'b0, 32'h4003_FFFC, 4'hF, 32'h0);
    check("shared last", rd, 32'h3C3C_C3C3);
  endtask : t_table
  task automatic t_remote;
    delay <= 8'h00;
    host(1'b0, 1'b0, 32'h8000_4024, 4'hF, 32'h0);
    check("remote addr", cap_addr, 32'h1234_5024);
    check("remote fields", {16'h0, cap}, {16'h0, 1'b0, 4'hF, 6'h3D, 2'b10, 3'h5});
    check("remote read error", {31'h0, err}, 32'h0);
    check("busy and local indicator", {31'h0, act}, 32'h1);
    check("remote read", rd, 32'h486E_5024);
    delay <= 8'h06;
    host(1'b1, 1'b0, 32'h8000_4102, 4'h4, 32'h0077_0000);
    check("remote write fields", {16'h0, cap}, {16'h0, 1'b1, 4'h4, 6'h3D, 2'b10, 3'h5});
    check("remote write data", cap_wd, 32'h0077_0000);
    check("remote write addr", cap_addr, 32'h1234_5102);
    host(1'b0, 1'b0, 32'h8000_6000, 4'hF, 32'h0);
    check("reserved dest err", {31'h0, err}, 32'h1);
  endtask : t_remote
  task automatic t_entry_width;
    host(1'b1, 1'b0, 32'h4000_0010, 4'hC, 32'h5555_0000);
    host(1'b1, 1'b0, 32'h4000_0010, 4'h1, 32'h0000_0000);
    check("byte write err", {31'h0, err}, 32'h1);
    host(1'b0, 1'b0, 32'h4000_0010, 4'hF, 32'h0);
    check("merged entry", rd, 32'h5555_5F6A);
  endtask : t_entry_width
  task automatic t_status;
    host(1'b0, 1'b0, 32'h8000_7000, 4'hF, 32'h0);
    check("invalid entry err", {31'h0, err}, 32'h1);
    remote_power_in <= 1'b0;
    host(1'b0, 1'b0, 32'h8000_4000, 4'hF, 32'h0);
    check("unlinked err", {31'h0, err}, 32'h1);
    host(1'b0, 1'b0, 32'h2000_0000, 4'hF, 32'h0);
    check("status unlinked", {28'h0, rd[3:0]}, 32'h0000_000B);
    remote_power_in <= 1'b1;
    @(posedge mclk_in);
    cable_err_in <= 1'b1;
    @(posedge mclk_in);
    cable_err_in <= 1'b0;
    host(1'b0, 1'b0, 32'h2000_0000, 4'hF, 32'h0);
    check("status linked", {28'h0, rd[3:0]}, 32'h0000_000E);
    host(1'b0, 1'b1, 32'h0000_1008, 4'hF, 32'h0);
    check("remote status", rd, 32'h0000_00C5);
    host(1'b0, 1'b0, 32'h2000_0000, 4'hF, 32'h0);
    check("cable err cleared", {28'h0, rd[3:0]}, 32'h0000_000A);
    host(1'b1, 1'b1, 32'h0000_1004, 4'hF, 32'h0000_0080);
    host(1'b0, 1'b0, 32'h2000_0000, 4'hF, 32'h0);
    check("errors cleared", {28'h0, rd[3:0]}, 32'h0000_0000);
  endtask : t_status
  task automatic t_indicators;
    @(posedge mclk_in);
    logic_loaded_in <= 1'b1;
    remote_master_in <= 1'b1;
    dma_active_in <= 1'b1;
    @(posedge mclk_in);
    #1 check("indicators on", {29'h0, loaded_ind, local_ind, remote_ind}, 32'h7);
    remote_master_in <= 1'b0;
    dma_active_in <= 1'b0;
    @(posedge mclk_in);
    #1 check("indicators off", {29'h0, loaded_ind, local_ind, remote_ind}, 32'h4);
  endtask : t_indicators
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge mclk_in);
    rst_in <= 1'b0;
    t_indicators();
    t_bases();
    cfg(8'h1C, 32'h8000_0000, 32'h8000_0000);
    t_table();
    t_remote();
    t_entry_width();
    t_status();
    wrap_up();
  end
endmodule : pci_remote_window_mapper_tb
